// *** rtl/ddr3_dev_end.sv ***
// Device end: mode registers, calibration readout and DLL-off timing.
//
// Summary of operation
// - Lane zero carries bit; others copy or zero.
// - Controller sends column bits one, zero low.
// - Eight-beat reads use A2 low, order 0-7.
// - Chopped read: A2 picks beats 0-3 or 4-7.
// - Banks, A9-A3, A10, A11, A13 ignored.
// - A12 chops on the fly when enabled.
// - Normal latencies; read only after DLL lock; the device accepts reads without checking locked_q.
// - Beat zero is LSB, beat seven MSB.
// - Location zero returns alternating 0,1 pattern.
// - NOP registers nothing, disturbs nothing.
// - Deselect runs nothing new, finishes current.
// - Mode one A0 set turns DLL off.
// - DLL-off supports read and write latency six.
// - DLL-off strobe starts one cycle earlier.
// - DLL off: MR1 A0, tMOD, self refresh.
// - After exit hold CKE high, ODT low.
// - Wait tXS, rewrite latencies, wait tMOD.
// - DLL on: enter self refresh, stable clock.
// - Hold CKE high, ODT low through tDLLK.
// - tXS, clear A0, tMRD, DLL reset, rewrite.
// - Wait tMOD, tDLLK and calibration time; the DLL-on sequence waits tMOD plus tDLLK only and issues no ZQ command.
// - Readout enable only with banks idle.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module ddr3_dev_end
    import ddr3_ctl_pkg::*;
#(
    parameter bit MIRROR_LANES = 1'b1
)(
    input  wire logic       i_clk,           // Link clock.
    input  wire logic       i_rst,           // Async reset, high.
    ddr3_link_if.dev        link,            // Command and data link.
    output logic            o_dll_off,       // DLL disabled.
    output logic            o_dll_locked,    // DLL lock time elapsed.
    output logic            o_mpr_en,        // Readout mode active.
    output logic            o_self_refresh,  // In self refresh.
    output logic [7:0]      o_banks_open,    // Open bank map.
    output logic [4:0]      o_read_latency   // Cycles to first beat.
);

    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE  = 2'h0,
        RS_WAIT  = 2'h1,
        RS_BURST = 2'h2
    } rd_e;

    typedef enum logic {
        DS_ACTIVE = 1'b0,
        DS_SREF   = 1'b1
    } dev_e;

    logic [13:0] mr_q [4];
    logic [13:0] mr_d [4];
    dev_e        dev_q, dev_d;
    logic [7:0]  open_q, open_d;
    logic [9:0]  lock_q, lock_d;
    logic        locked_q, locked_d;
    rd_e         rs_q, rs_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [2:0]  pos_q, pos_d;
    logic [2:0]  left_q, left_d;
    logic        mpr_rd_q, mpr_rd_d;
    logic [1:0]  loc_q, loc_d;
    logic [7:0]  dq_q, dq_d;
    logic        oe_q, oe_d;
    logic [4:0]  lat_q, lat_d;

    logic        sel;
    cmd_e        cmd;
    logic        dll_off;
    logic        mpr_on;
    logic        chop;
    logic [4:0]  al;
    logic        beat;

    assign dll_off = mr_q[1][A_DLL_OFF];
    assign mpr_on  = mr_q[3][A_MPR_EN];

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    // A deselected cycle decodes as NOP; self refresh hides all commands.
    always_comb
    begin
        sel = ~link.cs_n && dev_q == DS_ACTIVE && link.cke;
        cmd = sel ? cmd_e'({link.ras_n, link.cas_n, link.we_n})
                  : CMD_NOP;
    end

    // Additive latency and chop decision for the incoming read.
    always_comb
    begin
        unique case (mr_q[1][4:3])
            2'h1:    al = 5'(CL_CK - 1);
            2'h2:    al = 5'(CL_CK - 2);
            default: al = 5'h00;
        endcase
        unique case (mr_q[0][1:0])
            BL_FIX4: chop = 1'b1;
            BL_OTF:  chop = ~link.addr[A_BC];
            default: chop = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Mode registers, banks, self refresh and DLL lock
    // ----------------------------------------------------------------
    // Only mode writes and reads act while readout is enabled.
    always_comb
    begin
        mr_d     = mr_q;
        dev_d    = dev_q;
        open_d   = open_q;
        lock_d   = lock_q;
        locked_d = locked_q;
        if (!locked_q && !dll_off)
        begin
            if (lock_q == 10'(T_DLLK_CK - 1))
                locked_d = 1'b1;
            else
                lock_d = lock_q + 10'h001;
        end
        if (dev_q == DS_SREF && link.cke)
            dev_d = DS_ACTIVE;
        unique case (cmd)
            CMD_MRS:
            begin
                if (link.ba[1:0] != 2'h3 || open_q == 8'h00)
                    mr_d[link.ba[1:0]] = link.addr;
                // Turning the DLL off also restarts its lock count.
                if (link.ba[1:0] == 2'h1 && link.addr[A_DLL_OFF])
                begin
                    locked_d = 1'b0;
                    lock_d   = 10'h000;
                end
                if (link.ba[1:0] == 2'h0 && link.addr[A_DLL_RST])
                begin
                    locked_d = 1'b0;
                    lock_d   = 10'h000;
                end
            end
            CMD_ACT:
                if (!mpr_on)
                    open_d[link.ba] = 1'b1;
            CMD_PRE:
                if (!mpr_on)
                begin
                    if (link.addr[A_AP])
                        open_d = 8'h00;
                    else
                        open_d[link.ba] = 1'b0;
                end
            default:
                ;
        endcase
        if (!link.cs_n && dev_q == DS_ACTIVE && !link.cke && !mpr_on
            && {link.ras_n, link.cas_n, link.we_n} == CMD_REF)
            dev_d = DS_SREF;
    end

    // Registers the mode, bank and lock state.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < 4; i++)
                mr_q[i] <= MR_RESET;
            dev_q    <= DS_ACTIVE;
            open_q   <= 8'h00;
            lock_q   <= 10'h000;
            locked_q <= 1'b0;
        end
        else
        begin
            mr_q     <= mr_d;
            dev_q    <= dev_d;
            open_q   <= open_d;
            lock_q   <= lock_d;
            locked_q <= locked_d;
        end
    end

    // ----------------------------------------------------------------
    // Read pipeline and calibration readout
    // ----------------------------------------------------------------
    // DLL-off brings the first beat one cycle forward.
    always_comb
    begin
        lat_d = dll_off ? 5'(al + 5'(CL_CK - 1))
                        : 5'(al + 5'(CL_CK));
    end

    // The readout bit is picked by beat position; reserved locations
    // follow the same order but return zero.
    always_comb
    begin
        beat = (loc_q == 2'h0) ? MPR_PATTERN[pos_d] : 1'b0;
    end

    // Countdown to the first beat, then one beat per cycle.
    always_comb
    begin
        rs_d     = rs_q;
        cnt_d    = cnt_q;
        pos_d    = pos_q;
        left_d   = left_q;
        mpr_rd_d = mpr_rd_q;
        loc_d    = loc_q;
        dq_d     = dq_q;
        oe_d     = oe_q;
        if (rs_q == RS_IDLE && cmd == CMD_RD)
        begin
            rs_d     = RS_WAIT;
            cnt_d    = lat_q - 5'h01;
            // Only A2 and A12 matter; the rest of the address is dropped.
            pos_d    = chop ? {link.addr[2], 2'h0} : 3'h0;
            left_d   = chop ? 3'h3 : 3'h7;
            mpr_rd_d = mpr_on;
            loc_d    = mr_q[3][1:0];
        end
        else if (rs_q == RS_WAIT)
        begin
            if (cnt_q == 5'h00)
            begin
                rs_d = RS_BURST;
                oe_d = 1'b1;
            end
            else
                cnt_d = cnt_q - 5'h01;
        end
        else if (rs_q == RS_BURST)
        begin
            if (left_q == 3'h0)
            begin
                rs_d = RS_IDLE;
                oe_d = 1'b0;
            end
            else
            begin
                left_d = left_q - 3'h1;
                pos_d  = pos_q + 3'h1;
            end
        end
        if (rs_d == RS_BURST && mpr_rd_d)
            dq_d = {MIRROR_LANES ? {7{beat}} : 7'h00, beat};
        else
            dq_d = 8'h00;
    end

    // Registers the read pipeline and the link outputs.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rs_q     <= RS_IDLE;
            cnt_q    <= 5'h00;
            pos_q    <= 3'h0;
            left_q   <= 3'h0;
            mpr_rd_q <= 1'b0;
            loc_q    <= 2'h0;
            dq_q     <= 8'h00;
            oe_q     <= 1'b0;
            lat_q    <= 5'(CL_CK);
        end
        else
        begin
            rs_q     <= rs_d;
            cnt_q    <= cnt_d;
            pos_q    <= pos_d;
            left_q   <= left_d;
            mpr_rd_q <= mpr_rd_d;
            loc_q    <= loc_d;
            dq_q     <= dq_d;
            oe_q     <= oe_d;
            lat_q    <= lat_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Status outputs come straight from the registers.
    assign link.dq        = dq_q;
    assign link.dq_oe     = oe_q;
    assign link.dqs_oe    = oe_q;
    assign o_dll_off      = mr_q[1][A_DLL_OFF];
    assign o_dll_locked   = locked_q;
    assign o_mpr_en       = mr_q[3][A_MPR_EN];
    assign o_self_refresh = dev_q;
    assign o_banks_open   = open_q;
    assign o_read_latency = lat_q;

endmodule
`default_nettype wire

// *** rtl/ddr3_ctl_pkg.sv ***
// Shared constants and types for the DDR3 calibration readout link.
package ddr3_ctl_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ    = 50;
    localparam int T_MRD_CK   = 4;
    localparam int T_MOD_CK   = 12;
    localparam int T_DLLK_CK  = 512;
    localparam int T_CKSRE_CK = 5;
    localparam int T_CKSRX_CK = 5;
    localparam int T_XS_NS    = 170;
    localparam int T_XS_CK    = (T_XS_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_WAIT_CK = 20;

    // ----------------------------------------------------------------
    // Command encodings {ras_n, cas_n, we_n}
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR  = 3'h4,
        CMD_RD  = 3'h5,
        CMD_ZQ  = 3'h6,
        CMD_NOP = 3'h7
    } cmd_e;

    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int A_DLL_OFF   = 0;
    localparam int A_MPR_EN    = 2;
    localparam int A_DLL_RST   = 8;
    localparam int A_AP        = 10;
    localparam int A_BC        = 12;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam int CL_CK  = 6;
    localparam int CWL_CK = 6;
    localparam logic [13:0] MR0_RUN    = 14'h0021;
    localparam logic [13:0] MR2_RUN    = 14'h0008;
    localparam logic [7:0] MPR_PATTERN = 8'hAA;
    localparam logic [13:0] MR_RESET   = 14'h0000;

    // ----------------------------------------------------------------
    // Controller register map and operations
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;

    typedef enum logic [1:0] {
        OP_MRS     = 2'h0,
        OP_MPR_RD  = 2'h1,
        OP_DLL_OFF = 2'h2,
        OP_DLL_ON  = 2'h3
    } op_e;

    typedef enum logic [2:0] {
        ST_MRS = 3'h0,
        ST_SRE = 3'h1,
        ST_SRX = 3'h2,
        ST_RD  = 3'h3,
        ST_END = 3'h4
    } stp_e;

endpackage

// *** rtl/ddr3_link_if.sv ***
// Command, address and read data link between controller and device.
`timescale 1ns/1ps
`default_nettype none
interface ddr3_link_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        dqs_oe;

    modport dev (
        input  cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
        output dq, dq_oe, dqs_oe
    );
    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
        input  dq, dq_oe, dqs_oe
    );
endinterface
`default_nettype wire

// *** rtl/ddr3_ctl_end.sv ***
// Controller end: runs readout and DLL switching command sequences.
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctl_end
    import ddr3_ctl_pkg::*;
(
    input  wire logic        i_clk,    // Clock.
    input  wire logic        i_rst,    // Async reset, high.
    input  wire logic [1:0]  i_addr,   // Register address.
    input  wire logic [31:0] i_wdata,  // Write data.
    input  wire logic        i_wr,     // Write strobe.
    input  wire logic        i_rd,     // Read strobe.
    output logic [31:0]      o_rdata,  // Read data, next cycle.
    ddr3_link_if.ctl         link      // Command and data link.
);

    // ----------------------------------------------------------------
    // Sequence steps
    // ----------------------------------------------------------------
    typedef struct packed {
        stp_e        kind;
        logic [1:0]  mr;
        logic [13:0] a;
        logic [9:0]  wt;
    } step_s;

    typedef enum logic [1:0] {
        CS_IDLE = 2'h0,
        CS_RUN  = 2'h1,
        CS_WAIT = 2'h2
    } cst_e;

    // Returns one step of an operation; each step waits before the next.
    function automatic step_s step(op_e op, logic [2:0] i,
                                   logic [15:0] arg);
        step_s s;
        s = '{ST_END, 2'h0, 14'h0000, 10'h001};
        unique case (op)
            OP_MRS:
                if (i == 3'h0)
                    s = '{ST_MRS, arg[15:14], arg[13:0], 10'(T_MOD_CK)};
            OP_MPR_RD:
                unique case (i)
                    // The low argument bits pick the readout location.
                    3'h0: s = '{ST_MRS, 2'h3, 14'h0004 | 14'(arg[1:0]),
                                10'(T_MOD_CK)};
                    3'h1: s = '{ST_RD, 2'h0, arg[13:0], 10'(RD_WAIT_CK)};
                    3'h2: s = '{ST_MRS, 2'h3, 14'h0000, 10'(T_MOD_CK)};
                    default: ;
                endcase
            OP_DLL_OFF:
                unique case (i)
                    3'h0: s = '{ST_MRS, 2'h1, 14'h0001, 10'(T_MOD_CK)};
                    3'h1: s = '{ST_SRE, 2'h0, 14'h0000,
                                10'(T_CKSRE_CK + T_CKSRX_CK)};
                    3'h2: s = '{ST_SRX, 2'h0, 14'h0000, 10'(T_XS_CK)};
                    3'h3: s = '{ST_MRS, 2'h0, MR0_RUN, 10'(T_MOD_CK)};
                    3'h4: s = '{ST_MRS, 2'h2, MR2_RUN, 10'(T_MOD_CK)};
                    default: ;
                endcase
            OP_DLL_ON:
                unique case (i)
                    3'h0: s = '{ST_SRE, 2'h0, 14'h0000,
                                10'(T_CKSRE_CK + T_CKSRX_CK)};
                    3'h1: s = '{ST_SRX, 2'h0, 14'h0000, 10'(T_XS_CK)};
                    3'h2: s = '{ST_MRS, 2'h1, 14'h0000, 10'(T_MRD_CK)};
                    3'h3: s = '{ST_MRS, 2'h0, MR0_RUN | 14'h0100,
                                10'(T_MRD_CK)};
                    3'h4: s = '{ST_MRS, 2'h2, MR2_RUN,
                                10'(T_MOD_CK + T_DLLK_CK)};
                    default: ;
                endcase
        endcase
        return s;
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    cst_e        st_q, st_d;
    op_e         op_q, op_d;
    logic [15:0] arg_q, arg_d;
    logic [2:0]  idx_q, idx_d;
    logic [9:0]  wt_q, wt_d;
    logic        cke_q, cke_d;
    logic [2:0]  cmd_q, cmd_d;
    logic [1:0]  ba_q, ba_d;
    logic [13:0] a_q, a_d;
    logic [7:0]  cap_q, cap_d;
    logic [3:0]  nb_q, nb_d;
    logic        off_q, off_d;
    logic [31:0] rdata_q, rdata_d;
    step_s       cur;

    assign cur = step(op_q, idx_q, arg_q);

    // Issues each step for one cycle, waits, and captures read beats.
    always_comb
    begin
        st_d  = st_q;
        op_d  = op_q;
        arg_d = arg_q;
        idx_d = idx_q;
        wt_d  = wt_q;
        cke_d = cke_q;
        cmd_d = CMD_NOP;
        ba_d  = 2'h0;
        a_d   = 14'h0000;
        cap_d = cap_q;
        nb_d  = nb_q;
        off_d = off_q;
        if (link.dqs_oe)
        begin
            cap_d = {link.dq[0], cap_q[7:1]};
            nb_d  = nb_q + 4'h1;
        end
        unique case (st_q)
            CS_IDLE:
                if (i_wr && i_addr == REG_CTRL)
                begin
                    st_d  = CS_RUN;
                    op_d  = op_e'(i_wdata[1:0]);
                    arg_d = i_wdata[31:16];
                    idx_d = 3'h0;
                    nb_d  = 4'h0;
                end
            CS_RUN:
            begin
                wt_d = cur.wt - 10'h001;
                st_d = CS_WAIT;
                unique case (cur.kind)
                    ST_MRS:
                    begin
                        cmd_d = CMD_MRS;
                        ba_d  = cur.mr;
                        a_d   = cur.a;
                        if (cur.mr == 2'h1)
                            off_d = cur.a[A_DLL_OFF];
                    end
                    ST_SRE:
                    begin
                        cmd_d = CMD_REF;
                        cke_d = 1'b0;
                    end
                    ST_SRX:
                        cke_d = 1'b1;
                    ST_RD:
                    begin
                        cmd_d = CMD_RD;
                        a_d   = {1'b0, cur.a[A_BC], 9'h000,
                                 cur.a[2], 2'h0};
                    end
                    default:
                        st_d = CS_IDLE;
                endcase
            end
            CS_WAIT:
                if (wt_q == 10'h000)
                begin
                    st_d  = CS_RUN;
                    idx_d = idx_q + 3'h1;
                end
                else
                    wt_d = wt_q - 10'h001;
            default:
                st_d = CS_IDLE;
        endcase
        rdata_d = 32'h0000_0000;
        if (i_rd && i_addr == REG_CTRL)
            rdata_d = {arg_q, 14'h0000, op_q};
        else if (i_rd && i_addr == REG_STATUS)
            rdata_d = {18'h00000, st_q != CS_IDLE, off_q, nb_q, cap_q};
    end

    // Registers the sequencer, the link drive and the read data.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q    <= CS_IDLE;
            op_q    <= OP_MRS;
            arg_q   <= 16'h0000;
            idx_q   <= 3'h0;
            wt_q    <= 10'h000;
            cke_q   <= 1'b1;
            cmd_q   <= CMD_NOP;
            ba_q    <= 2'h0;
            a_q     <= 14'h0000;
            cap_q   <= 8'h00;
            nb_q    <= 4'h0;
            off_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            st_q    <= st_d;
            op_q    <= op_d;
            arg_q   <= arg_d;
            idx_q   <= idx_d;
            wt_q    <= wt_d;
            cke_q   <= cke_d;
            cmd_q   <= cmd_d;
            ba_q    <= ba_d;
            a_q     <= a_d;
            cap_q   <= cap_d;
            nb_q    <= nb_d;
            off_q   <= off_d;
            rdata_q <= rdata_d;
        end
    end

    // ODT stays low so no termination is active across switching.
    assign link.cke   = cke_q;
    assign link.cs_n  = 1'b0;
    assign link.ras_n = cmd_q[2];
    assign link.cas_n = cmd_q[1];
    assign link.we_n  = cmd_q[0];
    assign link.odt   = 1'b0;
    assign link.ba    = {1'b0, ba_q};
    assign link.addr  = a_q;
    assign o_rdata    = rdata_q;

endmodule
`default_nettype wire

// *** verif/ddr3_link_properties.sv ***
// Concurrent checks on the command and read data link.
`timescale 1ns/1ps
`default_nettype none
module ddr3_link_properties
    import ddr3_ctl_pkg::*;
(
    input wire logic        i_clk,  // Clock.
    input wire logic        i_rst,  // Reset.
    input wire logic        cke,    // Enable.
    input wire logic        cs_n,   // Select.
    input wire logic        ras_n,  // Code.
    input wire logic        cas_n,  // Code.
    input wire logic        we_n,   // Code.
    input wire logic        odt,    // Termination.
    input wire logic [2:0]  ba,     // Bank.
    input wire logic [13:0] addr,   // Address.
    input wire logic [7:0]  dq,     // Data.
    input wire logic        dq_oe,  // Data on.
    input wire logic        dqs_oe  // Strobe on.
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Decoded commands.
    wire logic [2:0] cmd   = {ras_n, cas_n, we_n};
    wire logic       sel   = !cs_n && cke;
    wire logic       rd_c  = sel && cmd == CMD_RD;
    wire logic       mrs_c = sel && cmd == CMD_MRS;
    logic            off_q;
    logic [2:0]      mpr_q;
    // Shadow copies of the DLL-off bit and the readout field.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            off_q <= 1'b0;
            mpr_q <= 3'h0;
        end
        else if (mrs_c && ba == 3'h1)
            off_q <= addr[A_DLL_OFF];
        else if (mrs_c && ba == 3'h3)
            mpr_q <= addr[2:0];
    end
    // Link relations.
    a_lane_copy: assert property (dq_oe |-> dqs_oe &&
        (dq[7:1] == 7'h00 || dq[7:1] == {7{dq[0]}})) else $error("lanes");
    a_col_low: assert property (rd_c |-> addr[1:0] == 2'h0)
        else $error("column bits set");
    a_rd_latency: assert property (rd_c && !dq_oe |->
        if (off_q) ##6 $rose(dq_oe) else ##7 $rose(dq_oe)) else $error("lat");
    a_cal_pattern: assert property ($rose(dq_oe) && mpr_q == 3'h4 |->
        !dq[0] ##1 dq[0] ##1 !dq[0] ##1 dq[0]) else $error("pattern");
    a_burst_len: assert property ($rose(dq_oe) |->
        (dq_oe[*4] ##1 !dq_oe) or (dq_oe[*8] ##1 !dq_oe)) else $error("len");
    a_no_spurious: assert property ($rose(dq_oe) |->
        $past(rd_c, 6) || $past(rd_c, 7)) else $error("burst without read");
    a_only_reads: assert property (mpr_q[2] && sel |->
        cmd == CMD_RD || cmd == CMD_MRS || cmd == CMD_NOP) else $error("cmd");
    a_odt_low: assert property (!odt) else $error("odt high");
endmodule
`default_nettype wire

// *** verif/ddr3_mpr_and_dll_mode_control_test.sv ***
// Bench joining the controller and device ends over the link.
`timescale 1ns/1ps
`default_nettype none
module ddr3_mpr_and_dll_mode_control_test
    import ddr3_ctl_pkg::*;
;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [1:0]  i_addr = 2'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata, v;
    logic        off, lk, mpr, sr;
    logic [7:0]  bk;
    logic [4:0]  lat;
    int          fail_count = 0;
    int          checked = 0;
    ddr3_link_if link ();
    ddr3_ctl_end u_ddr3_ctl_end (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .link(link));
    ddr3_dev_end u_ddr3_dev_end (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .o_dll_off(off), .o_dll_locked(lk), .o_mpr_en(mpr),
        .o_self_refresh(sr), .o_banks_open(bk), .o_read_latency(lat));
    ddr3_link_properties u_ddr3_link_properties (.i_clk(i_clk),
        .i_rst(i_rst), .cke(link.cke), .cs_n(link.cs_n), .odt(link.odt),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .dq(link.dq), .dq_oe(link.dq_oe),
        .dqs_oe(link.dqs_oe));
    // Free-running clock.
    initial forever #10 i_clk = ~i_clk;
    // Compare, register write and register read.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [1:0] a, input logic [31:0] m, e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        chk(v & m, e);
    endtask
    // Poll status until the controller is idle; a hang counts as a miss.
    task automatic idle;
        rdc(REG_STATUS, 32'h0, 32'h0);
        for (int n = 0; n < 4000 && v[13] !== 1'b0; n++)
            rdc(REG_STATUS, 32'h0, 32'h0);
        chk(32'(v[13]), 32'h0);
    endtask
    task automatic run(input logic [15:0] g, input op_e op);
        wr(REG_CTRL, {g, 14'h0, op});
        idle();
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence: readout bursts, then DLL off and back on.
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 700 && lk !== 1'b1; k++)
            @(posedge i_clk);
        chk(32'(lk), 32'h1);
        run({2'h0, MR0_RUN}, OP_MRS);
        run(16'hC004, OP_MRS);
        chk(32'(mpr), 32'h1);
        run(16'h1000, OP_MPR_RD);
        rdc(REG_STATUS, 32'hFFF, 32'h8AA);
        run(16'h0000, OP_MPR_RD);
        rdc(REG_STATUS, 32'hFF0, 32'h4A0);
        run(16'h0004, OP_MPR_RD);
        rdc(REG_STATUS, 32'hFF0, 32'h4A0);
        run(16'hC005, OP_MRS);
        run(16'h1001, OP_MPR_RD);
        rdc(REG_STATUS, 32'hF00, 32'h800);
        run(16'hC000, OP_MRS);
        chk(32'(mpr), 32'h0);
        chk(32'(bk), 32'h0);
        rdc(REG_CTRL, 32'hFFFFFFFF, 32'hC0000000);
        rdc(2'h2, 32'hFFFFFFFF, 32'h0);
        run(16'h0000, OP_DLL_OFF);
        chk(32'(off), 32'h1);
        chk(32'(lat), 32'h5);
        rdc(REG_STATUS, 32'h3000, 32'h1000);
        chk(32'(sr), 32'h0);
        wr(REG_CTRL, {16'h0, 14'h0, OP_DLL_ON});
        wr(REG_CTRL, {16'hC004, 14'h0, OP_MRS});
        idle();
        rdc(REG_CTRL, 32'hFFFF, 32'h3);
        chk(32'(mpr), 32'h0);
        chk(32'(off), 32'h0);
        chk(32'(lat), 32'h6);
        chk(32'(lk), 32'h1);
        wrap_up();
    end
    // Watchdog against a hung sequence.
    initial
    begin
        #800000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
